//--- scl_control.sv
// synthesizer control latches: decode, power-down, fastlock, test output
//
// Notes on behaviour
// - 24 bits shifted msb first on clock rise
// - strobe rise copies word into selected latch
// - function latch field layout as specified
// - divider word bits 23:22 ignored
// - control bits 1,0 steer word into reference, divider or function latch
// - count-hold bit holds both dividers in reset
// - hold release restarts dividers aligned together
// - power-down bits 3 and 21, gated by enable
// - enable pin low forces immediate power-down
// - bit a set, b clear: immediate power-down
// - both bits set: power-down at pump event
// - power-down loads divider and timeout counters
// - power-down three-states the charge pump
// - power-down resets digital lock detect
// - power-down removes bias, debiases input, buffer
// - serial register keeps working in power-down
// - test output follows three select bits
// - bit 9 enables fastlock
// - bit 10 picks fastlock mode 1 or 2
// - fastlock uses second pump current code
// - mode 1 follows pump-gain bit directly
// - mode 2 clears pump-gain after timeout
`timescale 1ns/1ns
`default_nettype none

module scl_control #(
    parameter logic [7:0] TIMEOUT_STEP = scl_pkg::TIMEOUT_STEP_DF
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // serial link and enable pin
    input  wire logic        ser_clk,
    input  wire logic        ser_data,
    input  wire logic        latch_strobe,
    input  wire logic        chip_enable,
    // inner synthesizer events and test sources
    input  wire logic        pump_event,
    input  wire logic        pd_cycle,
    input  wire logic [7:0]  mux_src,
    // divider settings
    output logic [21:0]      ref_latch_bits,
    output logic [12:0]      main_count,
    output logic [5:0]       swallow_count,
    output logic [1:0]       prescaler_sel,
    // charge pump
    output logic [2:0]       pump_current,
    output logic             pump_gain,
    output logic             pd_polarity,
    output logic             pump_tristate,
    // counters and power
    output logic             counter_reset,
    output logic             counter_restart,
    output logic             lock_detect_reset,
    output logic             bias_disable,
    output logic             rf_debias,
    output logic             ref_buffer_off,
    output logic             powered_down,
    // test output
    output logic             test_output_pin
);
    import scl_pkg::*;

    typedef struct packed {
        logic [1:0]         ce_s;
        logic [21:0]        ref_l;
        logic [12:0]        main_c;
        logic [5:0]         swallow_c;
        logic               gain;
        logic [23:2]        func;
        logic               hold_prev;
        logic               init_pend;
        logic               init_pulse;
        logic [TIMER_W-1:0] timer;
        logic               sync_pd;
        logic               pd;
        logic               cnt_rst;
        logic               restart;
        logic               tri_st;
        logic [2:0]         cur;
        logic               test_out;
    } scl_state_type;

    scl_state_type      q;
    scl_state_type      d;
    logic [WORD_W-1:0]  word;
    logic               word_valid;
    logic               ce;
    logic               fl_mode2;
    logic               async_pd;
    logic               armed;
    logic               pd_now;
    logic               expire;
    logic               sel_src;

    function automatic scl_sel_type sel_of(input logic [WORD_W-1:0] w);
        return scl_sel_type'(w[1:0]);
    endfunction

    function automatic logic [TIMER_W-1:0] timeout_load(
        input logic [3:0] code
    );
        return TIMER_W'(({4'h0, code} + 8'h01) * TIMEOUT_STEP);
    endfunction

    // serial register runs regardless of power state
    scl_serial_in u_rx (
        .mclk         (mclk),
        .reset        (reset),
        .ser_clk      (ser_clk),
        .ser_data     (ser_data),
        .latch_strobe (latch_strobe),
        .word         (word),
        .word_valid   (word_valid)
    );

    always_comb begin
        d        = q;
        d.ce_s   = {q.ce_s[0], chip_enable};
        ce       = q.ce_s[1];
        fl_mode2 = q.func[FL_FL_EN] & q.func[FL_FL_MODE];
        async_pd = q.func[FL_PD_A] & ~q.func[FL_PD_B];
        armed    = q.func[FL_PD_A] & q.func[FL_PD_B];
        pd_now   = ~ce | async_pd | q.sync_pd;
        expire   = fl_mode2 & q.gain & (q.timer == TIMER_ONE) & pd_cycle
                   & ~pd_now;
        // armed power-down waits for the next pump event
        d.sync_pd    = armed & ce & (q.sync_pd | pump_event);
        d.init_pulse = 1'b0;

        // timeout counter runs only in mode 2
        if (pd_now) begin
            d.timer = '0;
        end else if (fl_mode2 & q.gain) begin
            if (q.timer == '0) begin
                d.timer = timeout_load(q.func[FL_TC_HI:FL_TC_LO]);
            end else if (pd_cycle) begin
                d.timer = q.timer - TIMER_ONE;
            end
        end
        if (expire) begin
            d.gain = 1'b0;
        end

        // a new divider write wins over an expiry in the same cycle
        if (word_valid) begin
            case (sel_of(word))
                SEL_REF: begin
                    d.ref_l = word[RF_HI:RF_LO];
                end
                SEL_DIV: begin
                    // bits 23:22 are never looked at
                    d.main_c    = word[DV_MAIN_HI:DV_MAIN_LO];
                    d.swallow_c = word[DV_SW_HI:DV_SW_LO];
                    d.gain      = word[DV_GAIN];
                    d.timer     = '0;
                    if (q.init_pend) begin
                        d.init_pulse = 1'b1;
                        d.init_pend  = 1'b0;
                    end
                end
                SEL_FUNC: begin
                    d.func = word[23:2];
                end
                SEL_INIT: begin
                    d.func       = word[23:2];
                    d.init_pulse = 1'b1;
                    d.init_pend  = 1'b1;
                end
                default: begin
                    d.func = q.func;
                end
            endcase
        end

        d.pd        = pd_now;
        d.cnt_rst   = q.func[FL_HOLD] | pd_now | q.init_pulse;
        d.hold_prev = q.func[FL_HOLD];
        // both dividers restart on one common pulse
        d.restart   = q.hold_prev & ~q.func[FL_HOLD] & ~pd_now;
        d.tri_st    = pd_now | q.func[FL_HOLD] | q.func[FL_CP_OFF]
                      | q.init_pulse;
        d.cur       = q.gain ? q.func[FL_CUR_B_HI:FL_CUR_B_LO]
                             : q.func[FL_CUR_A_HI:FL_CUR_A_LO];
        d.test_out  = mux_src[q.func[FL_SEL_HI:FL_SEL_LO]];
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ref_latch_bits    = q.ref_l;
    assign main_count        = q.main_c;
    assign swallow_count     = q.swallow_c;
    assign prescaler_sel     = q.func[FL_PRE_HI:FL_PRE_LO];
    assign pump_current      = q.cur;
    assign pump_gain         = q.gain;
    assign pd_polarity       = q.func[FL_POL];
    assign pump_tristate     = q.tri_st;
    assign counter_reset     = q.cnt_rst;
    assign counter_restart   = q.restart;
    assign lock_detect_reset = q.pd;
    assign bias_disable      = q.pd;
    assign rf_debias         = q.pd;
    assign ref_buffer_off    = q.pd;
    assign powered_down      = q.pd;
    assign test_output_pin   = q.test_out;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence sync_arm_s;
        ce && armed && !q.sync_pd && pump_event;
    endsequence

    sequence sync_wait_s;
        ce && armed && !q.sync_pd && !pump_event;
    endsequence

    pin_pd_a: assert property (!ce |=> powered_down)
        else $error("enable low did not power down");
    async_pd_a: assert property (ce && async_pd |=> powered_down)
        else $error("asynchronous power-down missed");
    sync_wait_a: assert property (sync_wait_s |=> !powered_down)
        else $error("synchronous power-down entered early");
    sync_enter_a: assert property (sync_arm_s |=> ##1 powered_down)
        else $error("synchronous power-down not entered");
    pd_outputs_a: assert property (powered_down |-> pump_tristate
        && lock_detect_reset && bias_disable && counter_reset)
        else $error("power-down side effects missing");
    hold_reset_a: assert property (q.func[FL_HOLD] |=> counter_reset
        && pump_tristate)
        else $error("count hold did not reset counters");
    restart_a: assert property ($fell(q.func[FL_HOLD]) && !pd_now
        |=> counter_restart)
        else $error("no restart after hold release");
    current_a: assert property (##1 pump_current == ($past(q.gain)
        ? $past(q.func[FL_CUR_B_HI:FL_CUR_B_LO])
        : $past(q.func[FL_CUR_A_HI:FL_CUR_A_LO])))
        else $error("wrong pump current code");
    expire_a: assert property (expire && !word_valid |=> !pump_gain)
        else $error("timeout did not clear pump gain");
    mode1_a: assert property (!fl_mode2 && q.gain && !word_valid
        |=> pump_gain)
        else $error("pump gain dropped outside mode 2");

    // latch loads, one each for the reference, divider and function codes
    sequence func_write_s;
        word_valid && sel_of(word) == SEL_FUNC;
    endsequence

    sequence div_write_s;
        word_valid && sel_of(word) == SEL_DIV;
    endsequence

    sequence ref_write_s;
        word_valid && sel_of(word) == SEL_REF;
    endsequence

    // source picked by the select bits, for the output check
    assign sel_src = mux_src[q.func[FL_SEL_HI:FL_SEL_LO]];

    func_load_a: assert property (func_write_s |=>
        prescaler_sel == $past(word[FL_PRE_HI:FL_PRE_LO])
        && pd_polarity == $past(word[FL_POL]))
        else $error("function word not loaded");
    div_load_a: assert property (div_write_s |=>
        main_count == $past(word[DV_MAIN_HI:DV_MAIN_LO])
        && swallow_count == $past(word[DV_SW_HI:DV_SW_LO])
        && pump_gain == $past(word[DV_GAIN]))
        else $error("divider word not loaded");
    ref_load_a: assert property (ref_write_s |=>
        ref_latch_bits == $past(word[RF_HI:RF_LO]))
        else $error("reference word not loaded");
    func_keep_a: assert property (div_write_s |=> $stable(q.func))
        else $error("divider word disturbed function latch");
    test_out_a: assert property (##1
        test_output_pin == $past(sel_src))
        else $error("test output not following select bits");

    // power-down side effects
    timer_pd_a: assert property (pd_now |=> q.timer == '0)
        else $error("timeout counter not at load in power-down");
    restart_pd_a: assert property (pd_now |=> !counter_restart)
        else $error("restart pulse during power-down");
    pd_bias_a: assert property (powered_down |-> rf_debias
        && ref_buffer_off)
        else $error("input bias or buffer left on in power-down");
    sync_ce_a: assert property (!ce |=> !q.sync_pd)
        else $error("armed power-down kept with enable low");

    // fastlock gain and timer
    gain_hold_a: assert property (!q.func[FL_FL_EN] && !word_valid
        |=> $stable(pump_gain))
        else $error("pump gain moved with fastlock off");
    timer_load_a: assert property (fl_mode2 && q.gain
        && q.timer == '0 && !pd_now && !word_valid |=> q.timer != '0)
        else $error("timeout counter did not load");
endmodule

`default_nettype wire

//--- scl_serial_in.sv
// constants package and serial input shift register with pin synchronisers
`timescale 1ns/1ns
`default_nettype none

package scl_pkg;
    localparam int WORD_W      = 24;
    localparam int TIMER_W     = 8;
    localparam int SYNC_STAGES = 2;
    // latch select codes in the two low word bits
    typedef enum logic [1:0] {
        SEL_REF  = 2'b00,
        SEL_DIV  = 2'b01,
        SEL_FUNC = 2'b10,
        SEL_INIT = 2'b11
    } scl_sel_type;
    // reference latch payload
    localparam int RF_HI       = 23;
    localparam int RF_LO       = 2;
    // divider latch fields; bits 23:22 are ignored
    localparam int DV_GAIN     = 21;
    localparam int DV_MAIN_HI  = 20;
    localparam int DV_MAIN_LO  = 8;
    localparam int DV_SW_HI    = 7;
    localparam int DV_SW_LO    = 2;
    // function latch fields
    localparam int FL_PRE_HI   = 23;
    localparam int FL_PRE_LO   = 22;
    localparam int FL_PD_B     = 21;
    localparam int FL_CUR_B_HI = 20;
    localparam int FL_CUR_B_LO = 18;
    localparam int FL_CUR_A_HI = 17;
    localparam int FL_CUR_A_LO = 15;
    localparam int FL_TC_HI    = 14;
    localparam int FL_TC_LO    = 11;
    localparam int FL_FL_MODE  = 10;
    localparam int FL_FL_EN    = 9;
    localparam int FL_POL      = 8;
    localparam int FL_CP_OFF   = 7;
    localparam int FL_SEL_HI   = 6;
    localparam int FL_SEL_LO   = 4;
    localparam int FL_PD_A     = 3;
    localparam int FL_HOLD     = 2;
    localparam logic [TIMER_W-1:0] TIMER_ONE       = 8'h01;
    localparam logic [7:0]         TIMEOUT_STEP_DF = 8'h04;
endpackage

module scl_serial_in (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      reset,
    // serial pins
    input  wire logic                      ser_clk,
    input  wire logic                      ser_data,
    input  wire logic                      latch_strobe,
    // captured word
    output logic [scl_pkg::WORD_W-1:0]     word,
    output logic                           word_valid
);
    import scl_pkg::*;

    typedef struct packed {
        logic [2:0]        clk_s;
        logic [1:0]        dat_s;
        logic [2:0]        le_s;
        logic [WORD_W-1:0] shift;
        logic [WORD_W-1:0] word;
        logic              valid;
    } scl_rx_type;

    scl_rx_type q;
    scl_rx_type d;

    always_comb begin
        d = q;
        // stage 0 feeds only stage 1; stage 2 is the edge history
        d.clk_s = {q.clk_s[1:0], ser_clk};
        d.dat_s = {q.dat_s[0], ser_data};
        d.le_s  = {q.le_s[1:0], latch_strobe};
        d.valid = 1'b0;
        if (q.clk_s[1] & ~q.clk_s[2]) begin
            d.shift = {q.shift[WORD_W-2:0], q.dat_s[1]};
        end
        if (q.le_s[1] & ~q.le_s[2]) begin
            d.word  = q.shift;
            d.valid = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign word       = q.word;
    assign word_valid = q.valid;
endmodule

`default_nettype wire

//--- scl_host.sv
// host model driving the three-wire serial link
`timescale 1ns/1ns
`default_nettype none

module scl_host (
    // clock
    input  wire logic mclk,
    // serial pins
    output var logic  ser_clk,
    output var logic  ser_data,
    output var logic  latch_strobe
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch_strobe = 1'b0;
    end

    // 40 ns half period
    task automatic hw();
        repeat (10) @(negedge mclk);
    endtask

    task automatic write(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            hw();
            ser_clk = 1'b1;
            hw();
            ser_clk = 1'b0;
        end
        // released data line shows no stale bit
        ser_data = ~w[0];
        hw();
        latch_strobe = 1'b1;
        hw();
        latch_strobe = 1'b0;
    endtask
endmodule

`default_nettype wire

//--- testbench.sv
// self-checking bench for the synthesizer control latches
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import scl_pkg::*;
    localparam logic [7:0] STEP = 8'h02;
    logic        mclk, reset, chip_enable, pump_event, pd_cycle;
    logic [7:0]  mux_src;
    wire         ser_clk, ser_data, latch_strobe;
    logic [21:0] ref_latch_bits;
    logic [12:0] main_count;
    logic [5:0]  swallow_count;
    logic [1:0]  prescaler_sel;
    logic [2:0]  pump_current;
    logic        pump_gain, pd_polarity, pump_tristate, counter_reset;
    logic        lock_detect_reset, bias_disable, rf_debias, ref_buffer_off;
    logic        powered_down, test_output_pin, counter_restart;
    logic [23:0] ref_m, div_m, fn_m, w;
    logic        ce_m, spd_m, gain_m;
    logic [55:0] exp_q[$];
    int          n_errors, n_tests, cycles, seed, n_restart;
    event        chk;
    wire  [55:0] obs = {ref_latch_bits, main_count, swallow_count,
        prescaler_sel, pump_current, pump_gain, pd_polarity, pump_tristate,
        counter_reset, lock_detect_reset, bias_disable, rf_debias,
        ref_buffer_off, powered_down, test_output_pin};

    scl_host host (.mclk(mclk), .ser_clk(ser_clk), .ser_data(ser_data),
        .latch_strobe(latch_strobe));

    scl_control #(.TIMEOUT_STEP(STEP)) dut (.mclk(mclk), .reset(reset),
        .ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe),
        .chip_enable(chip_enable), .pump_event(pump_event),
        .pd_cycle(pd_cycle), .mux_src(mux_src),
        .ref_latch_bits(ref_latch_bits), .main_count(main_count),
        .swallow_count(swallow_count), .prescaler_sel(prescaler_sel),
        .pump_current(pump_current), .pump_gain(pump_gain),
        .pd_polarity(pd_polarity), .pump_tristate(pump_tristate),
        .counter_reset(counter_reset), .counter_restart(counter_restart),
        .lock_detect_reset(lock_detect_reset), .bias_disable(bias_disable),
        .rf_debias(rf_debias), .ref_buffer_off(ref_buffer_off),
        .powered_down(powered_down), .test_output_pin(test_output_pin));

    function automatic logic [55:0] obs_exp();
        logic pd;
        logic hd;
        pd = ~ce_m | (fn_m[FL_PD_A] & ~fn_m[FL_PD_B]) | spd_m;
        hd = fn_m[FL_HOLD];
        return {ref_m[RF_HI:RF_LO], div_m[DV_MAIN_HI:DV_MAIN_LO],
            div_m[DV_SW_HI:DV_SW_LO], fn_m[FL_PRE_HI:FL_PRE_LO],
            gain_m ? fn_m[FL_CUR_B_HI:FL_CUR_B_LO]
                   : fn_m[FL_CUR_A_HI:FL_CUR_A_LO],
            gain_m, fn_m[FL_POL], pd | hd | fn_m[FL_CP_OFF], hd | pd,
            {5{pd}}, mux_src[fn_m[FL_SEL_HI:FL_SEL_LO]]};
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cmp_obs(input logic [55:0] e, input logic [55:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED outputs expected %h seen %h", e, g);
        end
    endtask

    task automatic cmp_cnt(input int e, input int g);
        n_tests++;
        if (g != e) begin
            n_errors++;
            $display("CHECK FAILED restarts expected %0d seen %0d", e, g);
        end
    endtask

    // restart is a one-cycle pulse; count it away from its launch edge
    always @(negedge mclk) begin
        if (counter_restart === 1'b1) begin
            n_restart++;
        end
    end

    // note the expectation once outputs have settled
    task automatic note();
        repeat (12) @(negedge mclk);
        exp_q.push_back(obs_exp());
        -> chk;
    endtask

    task automatic wr(input logic [23:0] x);
        mux_src = 8'($random(seed));
        host.write(x);
        case (x[1:0])
            SEL_REF: ref_m = x;
            SEL_DIV: begin
                div_m = x;
                gain_m = x[DV_GAIN];
            end
            default: fn_m = x;
        endcase
        if (!(fn_m[FL_PD_A] & fn_m[FL_PD_B])) begin
            spd_m = 1'b0;
        end
        note();
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            pd_cycle = 1'b1;
            @(negedge mclk);
            pd_cycle = 1'b0;
            repeat (3) @(negedge mclk);
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            stop_test();
        end
    end

    initial forever begin
        @(chk);
        cmp_obs(exp_q.pop_front(), obs);
    end

    initial begin
        seed = 32'h2BC5;
        {reset, chip_enable, ce_m, pump_event, pd_cycle} = 5'h1C;
        {ref_m, div_m, fn_m, spd_m, gain_m, mux_src} = '0;
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        repeat (8) @(negedge mclk);
        wr(24'h000006);
        wr(24'h000002);
        cmp_cnt(1, n_restart);
        for (int i = 0; i < 8; i++) begin
            w = 24'($random(seed)) & 24'hDFF9F0;
            w[FL_SEL_HI:FL_SEL_LO] = 3'(i);
            w[1:0] = i[0] ? SEL_INIT : SEL_FUNC;
            wr(w);
            w = 24'($random(seed));
            w[1:0] = SEL_DIV;
            wr(w);
            w = 24'($random(seed));
            w[1:0] = SEL_REF;
            wr(w);
        end
        wr(24'h00000A);
        wr(24'h123455);
        wr(24'h000002);
        chip_enable = 1'b0;
        ce_m = 1'b0;
        note();
        wr(24'h0ABC01);
        chip_enable = 1'b1;
        ce_m = 1'b1;
        note();
        wr(24'h20000A);
        pump_event = 1'b1;
        @(negedge mclk);
        pump_event = 1'b0;
        spd_m = 1'b1;
        note();
        wr(24'h000002);
        for (int t = 0; t < 4; t += 3) begin
            wr(24'h150602 | 24'(t << FL_TC_LO));
            wr(24'h200101);
            tick((t + 1) * STEP - 1);
            note();
            tick(1);
            gain_m = 1'b0;
            note();
        end
        wr(24'h150202);
        wr(24'h200101);
        tick(8);
        note();
        wr(24'h000101);
        repeat (4) @(negedge mclk);
        cmp_cnt(1, n_restart);
        stop_test();
    end
endmodule

`default_nettype wire
